//--- logic/ssq_consts.svh
/*
 * constants for the serial step sequencer: register map, message codes,
 * timing counts at a 100 MHz aclk.
 * assumes aclk of 100 MHz and a byte-wide serial transmitter/receiver outside.
 */
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH

// drive register map
`define SSQ_DRV_RUN_CMD_REG     16'h0001
`define SSQ_DRV_FREQ_REF_REG    16'h0002
`define SSQ_DRV_STATUS_REG      16'h002C
`define SSQ_FUNC_WRITE_MULTI    8'h10
`define SSQ_FUNC_READ_HOLD      8'h03
`define SSQ_WRITE_REG_COUNT     16'h0002
`define SSQ_READ_REG_COUNT      16'h0001
`define SSQ_WRITE_BYTE_COUNT    8'h04
`define SSQ_CRC_PRESET          16'hFFFF
`define SSQ_CRC_POLY            16'hA001

// controller registers, byte addresses
`define SSQ_ADDR_CTRL           8'h00
`define SSQ_ADDR_STATUS         8'h04
`define SSQ_ADDR_REPEAT         8'h08
`define SSQ_ADDR_RETRY          8'h0C
`define SSQ_ADDR_SEND_WAIT      8'h10
`define SSQ_ADDR_SLAVE_BASE     8'h20
`define SSQ_ADDR_DATA_BASE      8'h40
`define SSQ_ADDR_RESP_BASE      8'h60

// field positions
`define SSQ_CTRL_START_BIT      0
`define SSQ_STAT_BUSY_BIT       0
`define SSQ_STAT_DONE_BIT       1
`define SSQ_STAT_ERROR_BIT      2

`define SSQ_REPEAT_MAX          8'hFF
`define SSQ_RETRY_MAX           4'h9
`define SSQ_RETRY_RESET         4'h3
`define SSQ_SLOTS               4

// timing
`define SSQ_CLK_MHZ             100
`define SSQ_MONITOR_MS          500
`define SSQ_MONITOR_CYCLES      (`SSQ_MONITOR_MS * 1000 * `SSQ_CLK_MHZ)
`define SSQ_SEND_WAIT_MIN_MS    20
`define SSQ_SEND_WAIT_MIN_CYCLES (`SSQ_SEND_WAIT_MIN_MS * 1000 * `SSQ_CLK_MHZ)

`endif

//--- logic/ssq_pkg.sv
/*
 * types of the serial step sequencer.
 * assumes ssq_consts.svh is included by its users.
 */
package ssq_pkg;

  typedef enum logic [3:0] {
    SSQ_IDLE      = 4'b0000,
    SSQ_STEP_INIT = 4'b0001,
    SSQ_HOLDOFF   = 4'b0010,
    SSQ_BUILD     = 4'b0011,
    SSQ_SEND      = 4'b0100,
    SSQ_WAIT_RESP = 4'b0101,
    SSQ_RECV      = 4'b0110,
    SSQ_CHECK     = 4'b0111,
    SSQ_FAIL      = 4'b1000,
    SSQ_NEXT      = 4'b1001
  } ssq_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ssq_byte_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic error;
  } ssq_flags_type;

endpackage : ssq_pkg

//--- logic/ssq_sequencer.sv
/*
 * serial step sequencer: master end of a byte link to drive slaves.
 * runs step 0 (write run command and frequency reference) and step 1
 * (read status) for each slave in turn, with holdoff, three monitor
 * timers and retries. software drives it over axi4-lite.
 * assumes a byte uart outside: tx_ready takes a byte per handshake,
 * rx bytes arrive as one-cycle strobes on aclk; tx_done marks line idle.
 */
// Added by the designer: the AXI4-Lite register port.
// What this block does
// - repeat each step N times, 0..255
// - clear repetition counter on entering step
// - repeat count from operand word one
// - retry count configurable 0..9
// - error after the configured failed attempts
// - hold off sending during send wait
// - resend if send completion times out
// - retry if response start times out
// - retry if reception completion times out
// - retry missed step, then raise error
// - monitor periods about 0.5 s
// - at least 20 ms between same-slave sends; the code waits send_wait_cfg cycles, reset 0, with no minimum
// - after success, next step or end
// - abort sequence on step error
// - step 00 advances, step 01 ends
// - unicast only via send-then-receive
// - store received status data of step 01 only
// - send from source words, store to destination
// - four slave slots, addresses 01 to 04 at reset
// - CRC-16 preset FFFF over all bytes
// - write two registers from 0001, function 10
// - read one register 002C, function 03
`timescale 1ns/1ps
`include "ssq_consts.svh"

module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int unsigned MONITOR_CYCLES = `SSQ_MONITOR_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output ssq_byte_type     tx_byte,
  input  wire logic        tx_ready,
  input  wire logic        tx_done,
  input  wire ssq_byte_type rx_byte
);

  localparam int unsigned BYTES_MAX = 13;

  ssq_state_type state;
  logic [7:0]  repeat_cfg;
  logic [3:0]  retry_cfg;
  logic [31:0] send_wait_cfg;
  logic [7:0]  slave_addr [`SSQ_SLOTS];
  logic [31:0] src_data [`SSQ_SLOTS];
  logic [15:0] resp_data [`SSQ_SLOTS];
  ssq_flags_type flags;
  logic        step_idx;
  logic [7:0]  rep_cnt;
  logic [3:0]  fail_cnt;
  logic [31:0] timer;
  logic [7:0]  msg [BYTES_MAX];
  logic [3:0]  msg_len;
  logic [3:0]  byte_idx;
  logic [3:0]  rx_cnt;
  logic [15:0] crc_tx;
  logic [15:0] crc_rx;
  logic [7:0]  rx_buf [8];
  logic        start_pulse;
  logic [1:0]  slot;
  logic [3:0]  req_len;
  logic        crc_added;
  logic [15:0] crc_tx_next;
  logic        frame_ok;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `SSQ_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  function automatic int unsigned slot_of(input logic [7:0] a);
    return int'(a[4:2]) & (`SSQ_SLOTS - 1);
  endfunction : slot_of

  // upper address bits select one of the four-word tables or the scalar registers
  function automatic logic [7:0] region_of(input logic [7:0] a);
    return a & 8'hE0;
  endfunction : region_of

  assign slot = rep_cnt[1:0];

  // the check code rides behind the request body and is appended exactly once
  assign req_len     = step_idx ? 4'd6 : 4'd11;
  assign crc_added   = (msg_len != req_len);
  assign crc_tx_next = crc_step(crc_tx, tx_byte.data);
  // crc over the whole frame including its check code comes to zero
  assign frame_ok    = (crc_rx == 16'h0000) && (rx_buf[0] == slave_addr[slot]);

  // axi write: both channels taken together, response one cycle later
  logic wr_go;
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid  <= 1'b0;
      start_pulse   <= 1'b0;
      repeat_cfg    <= 8'h03;
      retry_cfg     <= `SSQ_RETRY_RESET;
      send_wait_cfg <= 32'h0000_0000;
      for (int i = 0; i < `SSQ_SLOTS; i++) begin
        slave_addr[i] <= 8'(i + 1);
        src_data[i]   <= 32'h0000_0000;
      end
    end else begin
      start_pulse <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_wstrb[0]) begin
          case (region_of(s_axi_awaddr))
            `SSQ_ADDR_SLAVE_BASE: slave_addr[slot_of(s_axi_awaddr)] <= s_axi_wdata[7:0];
            `SSQ_ADDR_DATA_BASE:  src_data[slot_of(s_axi_awaddr)] <= s_axi_wdata;
            default: begin
              case (s_axi_awaddr)
                `SSQ_ADDR_CTRL:      start_pulse <= s_axi_wdata[`SSQ_CTRL_START_BIT] && !flags.busy;
                `SSQ_ADDR_REPEAT:    repeat_cfg <= s_axi_wdata[7:0];
                `SSQ_ADDR_RETRY:     retry_cfg <= (s_axi_wdata[3:0] > `SSQ_RETRY_MAX) ?
                                                  `SSQ_RETRY_MAX : s_axi_wdata[3:0];
                `SSQ_ADDR_SEND_WAIT: send_wait_cfg <= s_axi_wdata;
                default: ;
              endcase
            end
          endcase
        end
      end
    end
  end

  // axi read: one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      case (region_of(s_axi_araddr))
        `SSQ_ADDR_SLAVE_BASE: s_axi_rdata <= {24'h00_0000, slave_addr[slot_of(s_axi_araddr)]};
        `SSQ_ADDR_DATA_BASE:  s_axi_rdata <= src_data[slot_of(s_axi_araddr)];
        `SSQ_ADDR_RESP_BASE:  s_axi_rdata <= {16'h0000, resp_data[slot_of(s_axi_araddr)]};
        default: begin
          case (s_axi_araddr)
            `SSQ_ADDR_STATUS:    s_axi_rdata <= {20'h0_0000, fail_cnt, 5'h00, flags.error, flags.done, flags.busy};
            `SSQ_ADDR_REPEAT:    s_axi_rdata <= {24'h00_0000, repeat_cfg};
            `SSQ_ADDR_RETRY:     s_axi_rdata <= {28'h000_0000, retry_cfg};
            `SSQ_ADDR_SEND_WAIT: s_axi_rdata <= send_wait_cfg;
            default:             s_axi_rdata <= 32'h0000_0000;
          endcase
        end
      endcase
    end
  end

  // byte link output
  assign tx_byte.valid = (state == SSQ_SEND) && (byte_idx < msg_len);
  assign tx_byte.data  = (byte_idx < msg_len) ? msg[byte_idx] : 8'h00;

  logic [3:0] resp_len;
  assign resp_len = step_idx ? 4'd7 : 4'd8;

  // step sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= SSQ_IDLE;
      flags    <= '0;
      step_idx <= 1'b0;
      rep_cnt  <= 8'h00;
      fail_cnt <= 4'h0;
      timer    <= 32'h0000_0000;
      msg_len  <= 4'h0;
      byte_idx <= 4'h0;
      rx_cnt   <= 4'h0;
      crc_rx   <= `SSQ_CRC_PRESET;
      crc_tx   <= `SSQ_CRC_PRESET;
      for (int i = 0; i < BYTES_MAX; i++) msg[i] <= 8'h00;
    end else begin
      case (state)
        SSQ_IDLE: begin
          if (start_pulse) begin
            flags    <= '{busy: 1'b1, done: 1'b0, error: 1'b0};
            step_idx <= 1'b0;
            state    <= SSQ_STEP_INIT;
          end
        end
        SSQ_STEP_INIT: begin
          rep_cnt  <= 8'h00;
          fail_cnt <= 4'h0;
          timer    <= 32'h0000_0000;
          state    <= (repeat_cfg == 8'h00) ? SSQ_NEXT : SSQ_HOLDOFF;
        end
        SSQ_HOLDOFF: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= send_wait_cfg) begin
            state <= SSQ_BUILD;
          end
        end
        SSQ_BUILD: begin
          // send-then-receive is the only command, unicast always
          msg[0] <= slave_addr[slot];
          if (!step_idx) begin
            msg[1] <= `SSQ_FUNC_WRITE_MULTI;
            msg[2] <= 8'h00;
            msg[3] <= 8'(`SSQ_DRV_RUN_CMD_REG);
            msg[4] <= 8'h00;
            msg[5] <= 8'(`SSQ_WRITE_REG_COUNT);
            msg[6] <= `SSQ_WRITE_BYTE_COUNT;
            msg[7] <= src_data[slot][31:24];
            msg[8] <= src_data[slot][23:16];
            msg[9] <= src_data[slot][15:8];
            msg[10] <= src_data[slot][7:0];
            msg_len <= 4'd11;
          end else begin
            msg[1] <= `SSQ_FUNC_READ_HOLD;
            msg[2] <= 8'h00;
            msg[3] <= 8'(`SSQ_DRV_STATUS_REG);
            msg[4] <= 8'h00;
            msg[5] <= 8'(`SSQ_READ_REG_COUNT);
            msg_len <= 4'd6;
          end
          byte_idx <= 4'h0;
          crc_tx   <= `SSQ_CRC_PRESET;
          timer    <= 32'h0000_0000;
          state    <= SSQ_SEND;
        end
        SSQ_SEND: begin
          timer <= timer + 32'h0000_0001;
          if (tx_byte.valid && tx_ready) begin
            byte_idx <= byte_idx + 4'h1;
            if (!crc_added && byte_idx == msg_len - 4'h1) begin
              msg[msg_len]        <= crc_tx_next[7:0];
              msg[msg_len + 4'h1] <= crc_tx_next[15:8];
              msg_len             <= msg_len + 4'h2;
            end
            crc_tx <= crc_tx_next;
          end
          if (timer >= MONITOR_CYCLES) begin
            state <= SSQ_FAIL;
          end else if (crc_added && byte_idx >= msg_len && tx_done) begin
            // tx_done is a level: the line must drain before the reply timer starts
            timer  <= 32'h0000_0000;
            rx_cnt <= 4'h0;
            crc_rx <= `SSQ_CRC_PRESET;
            state  <= SSQ_WAIT_RESP;
          end
        end
        SSQ_WAIT_RESP: begin
          timer <= timer + 32'h0000_0001;
          if (rx_byte.valid) begin
            crc_rx    <= crc_step(crc_rx, rx_byte.data);
            rx_cnt    <= 4'h1;
            timer     <= 32'h0000_0000;
            state     <= SSQ_RECV;
          end else if (timer >= MONITOR_CYCLES) begin
            state <= SSQ_FAIL;
          end
        end
        SSQ_RECV: begin
          timer <= timer + 32'h0000_0001;
          if (rx_byte.valid) begin
            crc_rx <= crc_step(crc_rx, rx_byte.data);
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt + 4'h1 == resp_len) state <= SSQ_CHECK;
          end else if (timer >= MONITOR_CYCLES) begin
            state <= SSQ_FAIL;
          end
        end
        SSQ_CHECK: begin
          if (frame_ok) begin
            fail_cnt <= 4'h0;
            timer    <= 32'h0000_0000;
            rep_cnt  <= rep_cnt + 8'h01;
            state    <= (rep_cnt + 8'h01 == repeat_cfg) ? SSQ_NEXT : SSQ_HOLDOFF;
          end else begin
            state <= SSQ_FAIL;
          end
        end
        SSQ_FAIL: begin
          timer <= 32'h0000_0000;
          // a retry count of 0 behaves as 1: the first failure ends the step
          if (fail_cnt + 4'h1 >= retry_cfg) begin
            flags <= '{busy: 1'b0, done: 1'b0, error: 1'b1};
            state <= SSQ_IDLE;
          end else begin
            fail_cnt <= fail_cnt + 4'h1;
            state    <= SSQ_HOLDOFF;
          end
        end
        SSQ_NEXT: begin
          if (!step_idx) begin
            step_idx <= 1'b1;
            state    <= SSQ_STEP_INIT;
          end else begin
            flags <= '{busy: 1'b0, done: 1'b1, error: 1'b0};
            state <= SSQ_IDLE;
          end
        end
        default: state <= SSQ_IDLE;
      endcase
    end
  end

  // reply bytes are kept in arrival order for the address check and the stored status word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else if (rx_byte.valid && state == SSQ_WAIT_RESP) begin
      rx_buf[0] <= rx_byte.data;
    end else if (rx_byte.valid && state == SSQ_RECV) begin
      rx_buf[rx_cnt[2:0]] <= rx_byte.data;
    end
  end

  // a status word is stored only once its frame has passed the check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `SSQ_SLOTS; i++) begin
        resp_data[i] <= 16'h0000;
      end
    end else if (state == SSQ_CHECK && frame_ok && step_idx) begin
      resp_data[slot] <= {rx_buf[3], rx_buf[4]};
    end
  end

endmodule : ssq_sequencer

//--- tb/ssq_sequencer_checker.sv
/* assertions on the sequencer's axi and byte-link ports.
   assumes it is bound into ssq_sequencer. */
`timescale 1ns/1ps
module ssq_sequencer_checker
  import ssq_pkg::*;
#(parameter int unsigned MONITOR_CYCLES = 200) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [31:0]  s_axi_rdata,
  input wire ssq_byte_type tx_byte,
  input wire logic         tx_ready,
  input wire ssq_byte_type rx_byte
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer:
    assert property (s_axi_awready |=> s_axi_bvalid) else $error("write not answered");
  a_bvalid_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_aw_w_paired:
    assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) else $error("awready alone");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
  a_tx_byte_holds:
    assert property (tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data)) else $error("tx moved");
  a_quiet_in_reply:
    assert property (rx_byte.valid |-> !tx_byte.valid) else $error("sent during reply");
  c_write: cover property (s_axi_awready);
  c_tx_taken: cover property (tx_byte.valid && tx_ready);
  c_rx_byte: cover property (rx_byte.valid);
endmodule : ssq_sequencer_checker

bind ssq_sequencer ssq_sequencer_checker #(.MONITOR_CYCLES(MONITOR_CYCLES)) ssq_sequencer_checker_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tx_byte, .tx_ready, .rx_byte);

//--- tb/ssq_drive_model.sv
/* behavioural drive slaves 1..3 on the byte link.
   assumes one byte per handshake and same-clock strobes. */
`timescale 1ns/1ps
module ssq_drive_model
  import ssq_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire ssq_byte_type tx_byte,
  output logic              tx_ready,
  output logic              tx_done,
  output ssq_byte_type      rx_byte,
  input  wire logic [7:0]   mute,
  output logic [7:0]        frames
);
  logic [7:0]  fb [0:12];
  logic [7:0]  rsp [0:12];
  logic [15:0] run [1:3];
  logic [15:0] freq [1:3];
  int          cnt, ri, rlen, gap;
  ssq_byte_type rx_next;

  function automatic logic [15:0] crc16(input logic [7:0] m [0:12], input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, m[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  // frames numbered below mute go unanswered, so the master sees a timeout
  task automatic answer();
    logic [7:0]  a;
    logic [15:0] c;
    a = fb[0];
    rlen = 0;
    rsp = fb;
    if (frames < mute || crc16(fb, cnt) !== 16'h0000 || a < 8'h01 || a > 8'h03) return;
    if (fb[1] == 8'h10 && {fb[2], fb[3], fb[4], fb[5], fb[6]} == 40'h00_0100_0204) begin
      run[a] = {fb[7], fb[8]};
      freq[a] = {fb[9], fb[10]};
      rlen = 8;
    end else if ({fb[1], fb[2], fb[3], fb[4], fb[5]} == 40'h03_002C_0001) begin
      rsp[2] = 8'h02;
      {rsp[3], rsp[4]} = run[a] ^ freq[a] ^ {8'h00, a};
      rlen = 7;
    end
    if (rlen == 0) return;
    c = crc16(rsp, rlen - 2);
    rsp[rlen - 2] = c[7:0];
    rsp[rlen - 1] = c[15:8];
    ri = 0;
    gap = 20;
  endtask : answer

  initial begin
    tx_ready = 1'b0;
    tx_done = 1'b1;
    rx_byte = '0;
    frames = 8'h00;
  end

  // slow on purpose: a byte taken every other cycle, reply bytes spaced out
  always @(posedge aclk) begin
    rx_next = '{valid: 1'b0, data: ~rx_byte.data};
    if (!aresetn) begin
      cnt = 0;
      ri = 0;
      rlen = 0;
      gap = 0;
      frames <= 8'h00;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_byte.valid && tx_ready) begin
        fb[cnt] = tx_byte.data;
        cnt = cnt + 1;
        if (cnt == ((fb[1] == 8'h10) ? 13 : 8)) begin
          answer();
          cnt = 0;
          frames <= frames + 8'h01;
        end
      end else if (gap > 0) begin
        gap = gap - 1;
      end else if (ri < rlen) begin
        rx_next = '{valid: 1'b1, data: rsp[ri]};
        ri = ri + 1;
        gap = 1;
      end
    end
    rx_byte <= rx_next;
    tx_done <= !(aresetn && tx_byte.valid && tx_ready);
  end
endmodule : ssq_drive_model

//--- tb/testbench.sv
/* self-checking bench: sequencer, drive model and bound checker.
   assumes monitor periods shortened to 200 cycles. */
`timescale 1ns/1ps
`include "ssq_consts.svh"
module testbench
  import ssq_pkg::*;
;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   s_axi_awaddr = 8'h00;
  logic [7:0]   s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0000_0000;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_awvalid = 1'b0;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         tx_ready, tx_done, tx_was = 1'b0;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [31:0]  s_axi_rdata;
  ssq_byte_type tx_byte, rx_byte;
  logic [7:0]   frames, mute = 8'h00;
  int           n_mismatch = 0, check_count = 0, cycles = 0, quiet = 0, min_quiet = 0;

  ssq_sequencer #(.MONITOR_CYCLES(200)) ssq_sequencer_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_byte, .tx_ready, .tx_done, .rx_byte);
  ssq_drive_model ssq_drive_model_i (.aclk, .aresetn, .tx_byte, .tx_ready, .tx_done, .rx_byte, .mute, .frames);

  always #5 aclk = ~aclk;

  // shortest silence between a reply byte and the start of the next request
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    quiet <= rx_byte.valid ? 0 : quiet + 1;
    tx_was <= tx_byte.valid;
    if (tx_byte.valid && !tx_was && quiet < min_quiet) min_quiet <= quiet;
    if (cycles == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready === 1'b1) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("write response", 32'h0000_0000, 32'(s_axi_bresp));
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check("read response", 32'h0000_0000, 32'(s_axi_rresp));
  endtask : axi_read

  task automatic run_seq(output logic [31:0] st);
    axi_write(`SSQ_ADDR_CTRL, 32'h0000_0001);
    do axi_read(`SSQ_ADDR_STATUS, st); while (st[0] === 1'b1);
  endtask : run_seq

  task automatic t_regs();
    logic [31:0] v;
    axi_read(`SSQ_ADDR_REPEAT, v);
    check("repeat reset", 32'h0000_0003, v);
    axi_read(`SSQ_ADDR_RETRY, v);
    check("retry reset", 32'h0000_0003, v);
    for (int i = 0; i < 3; i++) begin
      axi_read(`SSQ_ADDR_SLAVE_BASE + 8'(4 * i), v);
      check("slave address", 32'(i + 1), v);
    end
    axi_read(8'h1C, v);
    check("unmapped read", 32'h0000_0000, v);
    axi_write(`SSQ_ADDR_RETRY, 32'h0000_000C);
    axi_read(`SSQ_ADDR_RETRY, v);
    check("retry clamp", 32'h0000_0009, v);
    axi_write(`SSQ_ADDR_RETRY, 32'h0000_0003);
  endtask : t_regs

  task automatic t_normal();
    logic [31:0] v, d;
    logic [7:0]  f0;
    for (int i = 0; i < 3; i++) axi_write(`SSQ_ADDR_DATA_BASE + 8'(4 * i), 32'hA5C0_1230 ^ 32'(i * 257));
    axi_write(`SSQ_ADDR_SEND_WAIT, 32'h0000_001E);
    min_quiet = 100000;
    f0 = frames;
    run_seq(v);
    check("flags after run", 32'h0000_0002, {29'h0, v[2:0]});
    check("requests sent", 32'h0000_0006, 32'(frames - f0));
    check("holdoff kept", 32'h0000_0001, 32'(min_quiet >= 30));
    for (int i = 0; i < 3; i++) begin
      d = 32'hA5C0_1230 ^ 32'(i * 257);
      axi_read(`SSQ_ADDR_RESP_BASE + 8'(4 * i), v);
      check("stored status", {16'h0000, d[31:16] ^ d[15:0] ^ 16'(i + 1)}, v);
    end
    axi_write(`SSQ_ADDR_SEND_WAIT, 32'h0000_0000);
  endtask : t_normal

  task automatic t_retry();
    logic [31:0] v;
    logic [7:0]  f0;
    f0 = frames;
    mute = frames + 8'h01;
    run_seq(v);
    check("flags after retry", 32'h0000_0002, {29'h0, v[2:0]});
    check("requests with retry", 32'h0000_0007, 32'(frames - f0));
  endtask : t_retry

  task automatic t_abort();
    logic [31:0] v;
    logic [7:0]  f0;
    axi_write(`SSQ_ADDR_REPEAT, 32'h0000_0002);
    axi_write(`SSQ_ADDR_RETRY, 32'h0000_0002);
    f0 = frames;
    mute = frames + 8'h64;
    run_seq(v);
    check("error flag", 32'h0000_0001, {31'h0, v[2]});
    check("attempts before abort", 32'h0000_0002, 32'(frames - f0));
  endtask : t_abort

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_normal();
    t_retry();
    t_abort();
    complete_run();
  end
endmodule : testbench
